// ===== logic/qaw_pkg.sv
// package for the q&a watchdog status and answer block
package qaw_pkg;
    localparam logic [1:0] QAW_CNT_INIT_M0 = 2'h3;
    localparam logic [1:0] QAW_CNT_INIT_M1 = 2'h1;
    localparam logic [2:0] QAW_SEQ_MIN = 3'h3;
    localparam logic [2:0] QAW_CYCLE_ANSW = 3'h4;
    localparam logic [7:0] QAW_ANSW_RST = 8'h00;
    localparam int QAW_BIT_FC = 7;
    localparam int QAW_BIT_CNT = 5;
    localparam int QAW_BIT_CHG = 4;
    localparam int QAW_BIT_ERR = 3;
    localparam int QAW_BIT_SEQ = 2;
    localparam int QAW_BIT_TO = 1;
    localparam int QAW_BIT_EARLY = 0;

    typedef enum logic [1:0] {
        QAW_WIN_CLOSED,
        QAW_WIN_RESP1,
        QAW_WIN_RESP2
    } qaw_window_e;

    typedef struct packed {
        logic [7:0] win1;
        logic [7:0] win2;
        logic [7:0] qa;
        logic mode;
    } qaw_cfg_s;
endpackage

// ===== logic/qaw_flag.sv
// one read-clear status flag, set wins over clear
`timescale 1ns/1ps
module qaw_flag
    import qaw_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic init,
    input wire logic set,
    input wire logic clr,
    output logic q_ff
);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= INIT;
        end else if (init) begin
            q_ff <= INIT;
        end else if (set) begin
            q_ff <= 1'b1;
        end else if (clr) begin
            q_ff <= 1'b0;
        end
    end
endmodule

// ===== logic/qaw_status_answer.sv
// q&a watchdog status register and answer register
`timescale 1ns/1ps
module qaw_status_answer
    import qaw_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reset_state,
    input wire qaw_cfg_s cfg,
    input wire qaw_window_e window,
    input wire logic cycle_end,
    input wire logic [7:0] expected_answer_byte,
    input wire logic answer_wr,
    input wire logic [7:0] answer_byte,
    input wire logic status_rd,
    input wire logic fail_at_threshold,
    output logic [7:0] status_rdata_ff,
    output logic answer_valid_ff,
    output logic [7:0] answer_ff
);
    qaw_cfg_s cfg_ff;
    logic cfg_change;
    logic [1:0] answer_counter_ff;
    logic [2:0] resp1_cnt_ff;
    logic [2:0] total_cnt_ff;
    logic closed_cnt_ff;
    logic any_wrong_ff;
    logic wrong_now;
    logic [2:0] resp1_fin;
    logic [2:0] total_fin;
    logic closed_fin;
    logic wrong_fin;
    logic reinit;
    logic config_changed_flag;
    logic wrong_answer_flag;
    logic sequence_error_flag;
    logic timeout_flag;
    logic early_answer_flag;
    logic failure_count_flag;
    logic set_err;
    logic set_seq;
    logic set_to;
    logic set_early;
    logic [7:0] nxt_status_rdata;

    // shadow copy of the config; any difference is a change
    assign cfg_change = (cfg != cfg_ff);
    // a mode change restarts the cycle bookkeeping like reset does
    assign reinit = reset_state || (cfg.mode != cfg_ff.mode);
    assign wrong_now = answer_wr && (answer_byte != expected_answer_byte);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= cfg;
        end
    end

    // answer register; not read back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            answer_ff <= QAW_ANSW_RST;
        end else if (reset_state) begin
            answer_ff <= QAW_ANSW_RST;
        end else if (answer_wr) begin
            answer_ff <= answer_byte;
        end
    end

    // strobe echo, one cycle after the write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            answer_valid_ff <= 1'b0;
        end else if (reset_state) begin
            answer_valid_ff <= 1'b0;
        end else begin
            answer_valid_ff <= answer_wr;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            answer_counter_ff <= QAW_CNT_INIT_M0;
        end else if (reinit) begin
            answer_counter_ff <= cfg.mode ? QAW_CNT_INIT_M1 : QAW_CNT_INIT_M0;
        end else if (answer_wr) begin
            answer_counter_ff <= answer_counter_ff + 2'h1;
        end
    end

    // counts include an answer landing in the cycle-end clock;
    // they saturate so runaway writes never wrap to a clean count
    assign resp1_fin = (resp1_cnt_ff == 3'h7) ? 3'h7
        : resp1_cnt_ff + {2'h0, answer_wr && window == QAW_WIN_RESP1};
    assign total_fin = (total_cnt_ff == 3'h7) ? 3'h7
        : total_cnt_ff + {2'h0, answer_wr};
    assign closed_fin = closed_cnt_ff
        || (answer_wr && window == QAW_WIN_CLOSED);
    assign wrong_fin = any_wrong_ff || wrong_now;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            resp1_cnt_ff <= 3'h0;
        end else if (reinit || cycle_end) begin
            resp1_cnt_ff <= 3'h0;
        end else begin
            resp1_cnt_ff <= resp1_fin;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            total_cnt_ff <= 3'h0;
        end else if (reinit || cycle_end) begin
            total_cnt_ff <= 3'h0;
        end else begin
            total_cnt_ff <= total_fin;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            closed_cnt_ff <= 1'b0;
        end else if (reinit || cycle_end) begin
            closed_cnt_ff <= 1'b0;
        end else begin
            closed_cnt_ff <= closed_fin;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            any_wrong_ff <= 1'b0;
        end else if (reinit || cycle_end) begin
            any_wrong_ff <= 1'b0;
        end else begin
            any_wrong_ff <= wrong_fin;
        end
    end

    assign set_err = cycle_end && wrong_fin;
    assign set_seq = cycle_end && !cfg.mode
        && resp1_fin < QAW_SEQ_MIN;
    assign set_to = cycle_end && (cfg.mode ? total_fin == 3'h0
        : total_fin < QAW_CYCLE_ANSW);
    assign set_early = cycle_end && (cfg.mode ? closed_fin
        : resp1_fin >= QAW_CYCLE_ANSW);

    // change flag restarts only on reset state, so a mode change shows
    qaw_flag #(.INIT(1'b0)) u_chg (
        .core_clk(core_clk),
        .nrst(nrst),
        .init(reset_state),
        .set(cfg_change),
        .clr(status_rd),
        .q_ff(config_changed_flag)
    );
    qaw_flag #(.INIT(1'b0)) u_err (
        .core_clk(core_clk),
        .nrst(nrst),
        .init(reinit),
        .set(set_err),
        .clr(status_rd),
        .q_ff(wrong_answer_flag)
    );
    qaw_flag #(.INIT(1'b0)) u_seq (
        .core_clk(core_clk),
        .nrst(nrst),
        .init(reinit),
        .set(set_seq),
        .clr(status_rd),
        .q_ff(sequence_error_flag)
    );
    qaw_flag #(.INIT(1'b0)) u_to (
        .core_clk(core_clk),
        .nrst(nrst),
        .init(reinit),
        .set(set_to),
        .clr(status_rd),
        .q_ff(timeout_flag)
    );
    qaw_flag #(.INIT(1'b0)) u_early (
        .core_clk(core_clk),
        .nrst(nrst),
        .init(reinit),
        .set(set_early),
        .clr(status_rd),
        .q_ff(early_answer_flag)
    );

    // bit 7 is 1 while below threshold; 0 is sticky until read below it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            failure_count_flag <= 1'b1;
        end else if (fail_at_threshold) begin
            failure_count_flag <= 1'b0;
        end else if (status_rd) begin
            failure_count_flag <= 1'b1;
        end
    end

    always_comb begin
        nxt_status_rdata = 8'h00;
        nxt_status_rdata[QAW_BIT_FC] = failure_count_flag;
        nxt_status_rdata[QAW_BIT_CNT +: 2] = answer_counter_ff;
        nxt_status_rdata[QAW_BIT_CHG] = config_changed_flag;
        nxt_status_rdata[QAW_BIT_ERR] = wrong_answer_flag;
        nxt_status_rdata[QAW_BIT_SEQ] = sequence_error_flag;
        nxt_status_rdata[QAW_BIT_TO] = timeout_flag;
        nxt_status_rdata[QAW_BIT_EARLY] = early_answer_flag;
    end

    // data captured pre-clear, one cycle after the read strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_rdata_ff <= 8'h00;
        end else if (status_rd) begin
            status_rdata_ff <= nxt_status_rdata;
        end
    end
endmodule

// ===== dv/qaw_props.sv
// concurrent checks on the status and answer ports
`timescale 1ns/1ps
module qaw_props
    import qaw_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reset_state,
    input wire qaw_cfg_s cfg,
    input wire qaw_window_e window,
    input wire logic cycle_end,
    input wire logic [7:0] expected_answer_byte,
    input wire logic answer_wr,
    input wire logic [7:0] answer_byte,
    input wire logic status_rd,
    input wire logic fail_at_threshold,
    input wire logic [7:0] status_rdata_ff,
    input wire logic answer_valid_ff,
    input wire logic [7:0] answer_ff
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_ok;
        !reset_state && !cycle_end && $stable(cfg);
    endsequence
    // quiet gap so no later cycle end can muddy the read
    sequence s_rd;
        !cycle_end && !status_rd && !reset_state && $stable(cfg)
        ##1 status_rd && !reset_state;
    endsequence
    sequence s_idle;
        cycle_end ##1 cycle_end && !answer_wr && !reset_state && $stable(cfg);
    endsequence
    sequence s_endw;
        cycle_end && answer_wr && !reset_state && $stable(cfg);
    endsequence
    answer_take_a: assert property (answer_wr && !reset_state
        |=> answer_valid_ff && answer_ff == $past(answer_byte))
        else $error("answer lost");
    flag_clear_a: assert property (status_rd ##0 s_ok ##1 s_ok
        ##1 status_rd |=> status_rdata_ff[4:0] == 5'h00)
        else $error("flags kept");
    fc_low_a: assert property ((fail_at_threshold && !reset_state)[*2]
        ##1 status_rd && !reset_state |=> !status_rdata_ff[7])
        else $error("fc high");
    fc_high_a: assert property (status_rd && !fail_at_threshold
        ##1 !fail_at_threshold ##1 status_rd && !fail_at_threshold
        |=> status_rdata_ff[7]) else $error("fc low");
    timeout_set_a: assert property (s_idle ##1 s_rd
        |=> status_rdata_ff[1]) else $error("no timeout");
    seq_set_a: assert property (s_idle ##0 !cfg.mode ##1 s_rd
        |=> status_rdata_ff[2]) else $error("no seq");
    early_set_a: assert property (s_endw ##0 cfg.mode
        ##0 window == QAW_WIN_CLOSED ##1 s_rd |=> status_rdata_ff[0])
        else $error("no early");
    wrong_set_a: assert property (s_endw
        ##0 answer_byte != expected_answer_byte ##1 s_rd
        |=> status_rdata_ff[3]) else $error("no wrong");
    set_wins_a: assert property (s_endw ##0 status_rd
        ##0 answer_byte != expected_answer_byte ##1 s_rd
        |=> status_rdata_ff[3]) else $error("clear won over set");
endmodule

// ===== dv/qaw_mcu.sv
// microcontroller model servicing the watchdog registers
`timescale 1ns/1ps
module qaw_mcu (
    input wire logic core_clk,
    output logic answer_wr = 1'b0,
    output logic [7:0] answer_byte = 8'h00,
    output logic status_rd = 1'b0
);
    // idle cycle after each access keeps strobes single-driven
    task automatic wr(input logic [7:0] b);
        answer_wr <= 1'b1;
        answer_byte <= b;
        @(posedge core_clk);
        answer_wr <= 1'b0;
        answer_byte <= ~b;
        @(posedge core_clk);
    endtask
    task automatic rd();
        status_rd <= 1'b1;
        @(posedge core_clk);
        status_rd <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule

// ===== dv/tb_top.sv
// testbench for the q&a watchdog status and answer block
`timescale 1ns/1ps
module tb_top
    import qaw_pkg::*;
;
    logic core_clk, nrst, reset_state, cycle_end, fail_at_threshold;
    qaw_cfg_s cfg;
    qaw_window_e window;
    logic [7:0] expected_answer_byte, answer_byte, status_rdata_ff, answer_ff;
    logic answer_wr, status_rd, answer_valid_ff;
    int fail_count, checks;
    qaw_status_answer qaw_status_answer_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .reset_state(reset_state),
        .cfg(cfg),
        .window(window),
        .cycle_end(cycle_end),
        .expected_answer_byte(expected_answer_byte),
        .answer_wr(answer_wr),
        .answer_byte(answer_byte),
        .status_rd(status_rd),
        .fail_at_threshold(fail_at_threshold),
        .status_rdata_ff(status_rdata_ff),
        .answer_valid_ff(answer_valid_ff),
        .answer_ff(answer_ff)
    );
    qaw_mcu qaw_mcu_i (
        .core_clk(core_clk),
        .answer_wr(answer_wr),
        .answer_byte(answer_byte),
        .status_rd(status_rd)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic ends(input int n);
        cycle_end <= 1'b1;
        repeat (n) @(posedge core_clk);
        cycle_end <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [7:0] exp);
        qaw_mcu_i.rd();
        chk(status_rdata_ff, exp);
    endtask
    initial begin
        {nrst, reset_state, cycle_end, fail_at_threshold} = 4'h0;
        cfg = 25'h0;
        window = QAW_WIN_CLOSED;
        expected_answer_byte = 8'h5A;
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rdc(8'hE0);
        ends(2);
        rdc(8'hE6);
        rdc(8'hE0);
        // answers held back until the timeout was seen
        window <= QAW_WIN_RESP1;
        qaw_mcu_i.wr(8'h5A);
        rdc(8'h80);
        qaw_mcu_i.wr(8'h5A);
        qaw_mcu_i.wr(8'h5A);
        fork
            qaw_mcu_i.wr(8'hA5);
            ends(1);
        join
        rdc(8'hE9);
        chk(answer_ff, 8'hA5);
        repeat (3) qaw_mcu_i.wr(8'h5A);
        window <= QAW_WIN_RESP2;
        fork
            qaw_mcu_i.wr(8'h5A);
            ends(1);
        join
        rdc(8'hE0);
        cfg.win1 <= 8'h11;
        @(posedge core_clk);
        rdc(8'hF0);
        fail_at_threshold <= 1'b1;
        repeat (2) @(posedge core_clk);
        rdc(8'h60);
        fail_at_threshold <= 1'b0;
        rdc(8'h60);
        rdc(8'hE0);
        cfg.mode <= 1'b1;
        @(posedge core_clk);
        rdc(8'hB0);
        window <= QAW_WIN_CLOSED;
        fork
            qaw_mcu_i.wr(8'h5A);
            ends(1);
        join
        rdc(8'hC1);
        ends(2);
        rdc(8'hC2);
        fork
            qaw_mcu_i.rd();
            qaw_mcu_i.wr(8'hA5);
            ends(1);
        join
        chk(status_rdata_ff, 8'hC0);
        rdc(8'hE9);
        reset_state <= 1'b1;
        @(posedge core_clk);
        reset_state <= 1'b0;
        rdc(8'hA0);
        chk(answer_ff, QAW_ANSW_RST);
        test_done();
    end
endmodule
bind qaw_status_answer qaw_props qaw_props_i (
    .core_clk(core_clk),
    .nrst(nrst),
    .reset_state(reset_state),
    .cfg(cfg),
    .window(window),
    .cycle_end(cycle_end),
    .expected_answer_byte(expected_answer_byte),
    .answer_wr(answer_wr),
    .answer_byte(answer_byte),
    .status_rd(status_rd),
    .fail_at_threshold(fail_at_threshold),
    .status_rdata_ff(status_rdata_ff),
    .answer_valid_ff(answer_valid_ff),
    .answer_ff(answer_ff)
);
